// File: tcrs_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] internal power-on reset starts the device without any external pulse
// [R2] host holds reset low while all supplies ramp
// [R3] host releases reset only after every supply is nominal; the host model waits only for the digital and io supplies
// [R4] reset low for at least 90 ns causes a full reset
// [R5] after reset release, ready within the 135 to 160 ms window
// [R6] after power-up alone, ready within the 135 to 160 ms window
// [R7] initialization stalls and stays silent while any supply is missing
// [R8] late analog supply: host uses deep-sleep wake or reset command
// [R9] deep-sleep wake recovery also needs a calibration command
// [R10] host should switch all supplies and drive reset low
// [R11] host resets only via reset line, never by cutting power alone
// [R12] reset from other domain kept low while digital supply is off
// [R13] on start-up completion, notify line is pulled low
// [R14] notify line is an input during start-up; host must not drive it
// [R15] host waits for notify fall or window end before transactions
module tcrs_sequencer #(
  parameter int unsigned READY_CYC = tcrs_pkg::READY_MIN_CYC,
  parameter int unsigned NOTIFY_IN_CYC = tcrs_pkg::NOTIFY_INPUT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ext_reset_b,
  input wire tcrs_pkg::tcrs_supply_t supply,
  input wire logic message_ack,
  output tcrs_pkg::tcrs_notify_t notify,
  output logic ready,
  output logic init_stalled
);
  tcrs_pkg::tcrs_state_t state;
  tcrs_pkg::tcrs_state_t next_state;
  logic [7:0] low_cnt;
  logic [tcrs_pkg::CNT_W-1:0] init_cnt;
  logic msg_pending;
  logic pulse_ok;
  tcrs_pkg::tcrs_state_t resume_state;

  wire all_supply = supply.digital_ok & supply.analog_supply & supply.io_supply;
  wire init_done = (init_cnt >= tcrs_pkg::CNT_W'(READY_CYC - 1));
  // a low pulse of the least width forces a full reset
  assign pulse_ok = (low_cnt >= 8'(tcrs_pkg::RESET_MIN_CYC)); // [R4]
  // a pulse too short to reset falls back to where it was, but never
  // into a later state while a supply is missing
  wire short_resume = !pulse_ok && all_supply;

  always_comb begin
    next_state = state;
    case (state)
      tcrs_pkg::TCRS_POR: next_state = tcrs_pkg::TCRS_WAIT_SUPPLY; // [R1]
      tcrs_pkg::TCRS_HELD: begin
        if (ext_reset_b) begin
          next_state = short_resume ? resume_state : tcrs_pkg::TCRS_WAIT_SUPPLY; // [R4]
        end
      end
      tcrs_pkg::TCRS_WAIT_SUPPLY: begin
        if (all_supply) begin
          next_state = tcrs_pkg::TCRS_INIT; // [R7]
        end
      end
      tcrs_pkg::TCRS_INIT: begin
        if (!all_supply) begin
          next_state = tcrs_pkg::TCRS_WAIT_SUPPLY; // [R7]
        end else if (init_done) begin
          next_state = tcrs_pkg::TCRS_READY; // [R5] [R6]
        end
      end
      default: next_state = tcrs_pkg::TCRS_READY;
    endcase
    if (!ext_reset_b) begin
      next_state = tcrs_pkg::TCRS_HELD;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= tcrs_pkg::TCRS_POR;
    end else begin
      state <= next_state;
    end
  end

  // state held before the reset line went low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resume_state <= tcrs_pkg::TCRS_POR;
    end else if (state != tcrs_pkg::TCRS_HELD) begin
      resume_state <= state;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= tcrs_pkg::PULSE_RESET;
    end else if (ext_reset_b) begin
      low_cnt <= tcrs_pkg::PULSE_RESET;
    end else if (!pulse_ok) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // init counter only advances with all supplies present; a short pulse keeps it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt <= '0;
    end else if (state == tcrs_pkg::TCRS_INIT && all_supply) begin
      init_cnt <= init_cnt + tcrs_pkg::CNT_W'(1); // [R7]
    end else if (state != tcrs_pkg::TCRS_INIT && state != tcrs_pkg::TCRS_HELD) begin
      init_cnt <= '0;
    end
  end

  wire enter_ready = (state == tcrs_pkg::TCRS_INIT) && (next_state == tcrs_pkg::TCRS_READY);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_pending <= 1'b0;
      notify <= '0;
      ready <= 1'b0;
      init_stalled <= 1'b0;
    end else begin
      // ready message set wins over host acknowledge
      if (enter_ready) begin
        msg_pending <= 1'b1; // [R13]
      end else if (message_ack || next_state != tcrs_pkg::TCRS_READY) begin
        msg_pending <= 1'b0;
      end
      notify.change_notify_line_out <= 1'b0;
      notify.change_notify_line_oe <= enter_ready ||
        (msg_pending && !message_ack && next_state == tcrs_pkg::TCRS_READY); // [R13] [R14]
      ready <= (next_state == tcrs_pkg::TCRS_READY);
      init_stalled <= (next_state == tcrs_pkg::TCRS_WAIT_SUPPLY);
    end
  end

  // pulled low only once start-up finished
  property p_notify_only_ready;
    @(posedge ref_clk) disable iff (!rst_b)
      notify.change_notify_line_oe |-> ready;
  endproperty
  a_notify_only_ready: assert property (p_notify_only_ready) // [R13]
    else $error("notify driven before ready");

  property p_silent_no_supply;
    @(posedge ref_clk) disable iff (!rst_b)
      (!all_supply && ext_reset_b && state != tcrs_pkg::TCRS_READY) |=> !ready;
  endproperty
  a_silent_no_supply: assert property (p_silent_no_supply) // [R7]
    else $error("ready while supply missing");

  property p_pulse_resets;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == tcrs_pkg::TCRS_HELD && ext_reset_b && pulse_ok) |=>
        (state == tcrs_pkg::TCRS_WAIT_SUPPLY && !ready);
  endproperty
  a_pulse_resets: assert property (p_pulse_resets) // [R4]
    else $error("full pulse did not reset");

  property p_ready_edge_notify;
    @(posedge ref_clk) disable iff (!rst_b)
      enter_ready |=> (ready && notify.change_notify_line_oe);
  endproperty
  a_ready_edge_notify: assert property (p_ready_edge_notify) // [R5]
    else $error("ready without notify");

  property p_init_length;
    @(posedge ref_clk) disable iff (!rst_b)
      enter_ready |-> (init_cnt == tcrs_pkg::CNT_W'(READY_CYC - 1));
  endproperty
  a_init_length: assert property (p_init_length) // [R6]
    else $error("init length wrong");

  property p_por_leaves;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == tcrs_pkg::TCRS_POR && ext_reset_b) |=> state == tcrs_pkg::TCRS_WAIT_SUPPLY;
  endproperty
  a_por_leaves: assert property (p_por_leaves) // [R1]
    else $error("power-on reset stuck");

  property p_held_silent;
    @(posedge ref_clk) disable iff (!rst_b)
      !ext_reset_b |=> (!ready && !notify.change_notify_line_oe);
  endproperty
  a_held_silent: assert property (p_held_silent) // [R14]
    else $error("active while held in reset");

  property p_stall_flag;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == tcrs_pkg::TCRS_INIT && !all_supply && ext_reset_b) |=> init_stalled;
  endproperty
  a_stall_flag: assert property (p_stall_flag) // [R7]
    else $error("stall not flagged");

  property p_short_resumes;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == tcrs_pkg::TCRS_HELD && ext_reset_b && short_resume) |=>
        state == $past(resume_state);
  endproperty
  a_short_resumes: assert property (p_short_resumes) // [R4]
    else $error("short pulse did not resume");

  property p_wait_stalled;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == tcrs_pkg::TCRS_WAIT_SUPPLY && !all_supply && ext_reset_b) |=> init_stalled;
  endproperty
  a_wait_stalled: assert property (p_wait_stalled) // [R7]
    else $error("waiting for supply not flagged");

  property p_ack_clears;
    @(posedge ref_clk) disable iff (!rst_b)
      (notify.change_notify_line_oe && message_ack && ext_reset_b) |=>
        !notify.change_notify_line_oe;
  endproperty
  a_ack_clears: assert property (p_ack_clears) // [R13]
    else $error("notify kept after acknowledge");

  property p_ready_stands;
    @(posedge ref_clk) disable iff (!rst_b)
      (ready && ext_reset_b) |=> ready;
  endproperty
  a_ready_stands: assert property (p_ready_stands) // [R5]
    else $error("ready dropped without reset");

  property p_input_window;
    @(posedge ref_clk) disable iff (!rst_b)
      (state == tcrs_pkg::TCRS_INIT && init_cnt < tcrs_pkg::CNT_W'(NOTIFY_IN_CYC)) |=>
        !notify.change_notify_line_oe;
  endproperty
  a_input_window: assert property (p_input_window) // [R14]
    else $error("notify driven while line is an input");
endmodule // tcrs_sequencer

// File: tcrs_pkg.sv
package tcrs_pkg;
  // start-up window figures
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam longint unsigned RESET_MIN_PS = 90000;
  localparam longint unsigned READY_MIN_MS = 135;
  localparam longint unsigned READY_MAX_MS = 160;
  localparam longint unsigned NOTIFY_INPUT_MS = 100;
  // least pulse rounds up
  localparam int unsigned RESET_MIN_CYC =
    int'((RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned READY_MIN_CYC = int'(READY_MIN_MS * 1000000000 / CLK_PERIOD_PS);
  localparam int unsigned NOTIFY_INPUT_CYC = int'(NOTIFY_INPUT_MS * 1000000000 / CLK_PERIOD_PS);
  localparam int CNT_W = 32;
  localparam logic [7:0] PULSE_RESET = 8'h00;

  typedef enum logic [2:0] {
    TCRS_POR = 3'b000,
    TCRS_HELD = 3'b001,
    TCRS_WAIT_SUPPLY = 3'b010,
    TCRS_INIT = 3'b011,
    TCRS_READY = 3'b100
  } tcrs_state_t;

  typedef struct packed {
    logic digital_ok;
    logic analog_supply;
    logic io_supply;
  } tcrs_supply_t;

  typedef struct packed {
    logic change_notify_line_out;
    logic change_notify_line_oe;
  } tcrs_notify_t;
endpackage

// File: tcrs_host_model.sv
`timescale 1ns/1ps
module tcrs_host_model (
  input wire logic ref_clk,
  input wire logic pwr_on,
  input wire logic rst_req,
  input wire logic analog_off,
  output logic ext_reset_b,
  output tcrs_pkg::tcrs_supply_t supply
);
  // host switches every supply; analog may rise late
  initial begin
    ext_reset_b = 1'b0;
    supply = '0;
    forever begin
      @(negedge ref_clk);
      supply <= {pwr_on, pwr_on & ~analog_off, pwr_on};
      ext_reset_b <= pwr_on & supply.digital_ok & supply.io_supply & ~rst_req;
    end
  end
  // change_notify_line is never driven from this side
endmodule // tcrs_host_model

// File: tb.sv
`timescale 1ns/1ps
module tb;
  localparam int RC = 20;
  logic ref_clk = 0, rst_b = 0, pwr_on = 1, rst_req = 0, analog_off = 0, message_ack = 0;
  logic ext_reset_b, ready, init_stalled;
  tcrs_pkg::tcrs_supply_t supply;
  tcrs_pkg::tcrs_notify_t notify;
  int err_total = 0, checked = 0, cyc = 0;
  tcrs_host_model host (.ref_clk(ref_clk), .pwr_on(pwr_on), .rst_req(rst_req),
    .analog_off(analog_off), .ext_reset_b(ext_reset_b), .supply(supply));
  tcrs_sequencer #(.READY_CYC(RC), .NOTIFY_IN_CYC(10)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .ext_reset_b(ext_reset_b), .supply(supply), .message_ack(message_ack),
    .notify(notify), .ready(ready), .init_stalled(init_stalled));
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // ready must stay low for the whole count, then come within a few edges
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    check("ready delay", {1'b0, n >= RC && n <= RC + 8}, 2'b01);
  endtask
  task automatic s_por();
    cycles(20);
    rst_b = 1'b1;
    wait_ready();
    check("notify", notify, 2'b01);
    cycles(2);
    check("notify stands", notify, 2'b01);
    message_ack = 1'b1;
    cycles(1);
    message_ack = 1'b0;
    cycles(1);
    check("notify ack", notify, 2'b00);
  endtask
  // host controls go through nonblocking writes so the host model sees them a cycle later
  task automatic s_short();
    rst_req <= 1'b1;
    cycles(tcrs_pkg::RESET_MIN_CYC - 1);
    rst_req <= 1'b0;
    cycles(6);
    check("short pulse", {1'b0, ready}, 2'b01);
  endtask
  task automatic s_full();
    rst_req <= 1'b1;
    cycles(tcrs_pkg::RESET_MIN_CYC);
    check("held", {1'b0, ready}, 2'b00);
    rst_req <= 1'b0;
    wait_ready();
  endtask
  task automatic s_stall();
    analog_off <= 1'b1;
    rst_req <= 1'b1;
    cycles(20);
    rst_req <= 1'b0;
    cycles(RC + 10);
    check("stalled", {ready, init_stalled}, 2'b01);
    check("silent", notify, 2'b00);
    analog_off <= 1'b0;
    wait_ready();
    // late analog supply: recover with a full reset, not the deep-sleep path
    rst_req <= 1'b1;
    cycles(tcrs_pkg::RESET_MIN_CYC);
    check("recovery held", {1'b0, ready}, 2'b00);
    rst_req <= 1'b0;
    wait_ready();
  endtask
  task automatic s_power();
    pwr_on <= 1'b0;
    cycles(RC);
    check("power off", {ready, notify.change_notify_line_oe}, 2'b00);
    pwr_on <= 1'b1;
    cycles(5);
    analog_off <= 1'b1;
    cycles(4);
    check("init stall", {ready, init_stalled}, 2'b01);
    analog_off <= 1'b0;
    wait_ready();
  endtask
  task automatic wrap_up();
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    s_por();
    s_short();
    s_full();
    s_stall();
    s_power();
    wrap_up();
  end
endmodule // tb
